// ===== sdram_device.sv
// Memory end: burst read and write engine with a small storage array.
// Assumes commands arrive synchronous to sys_clk_in from one controller.
module sdram_device (
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	input wire logic ce_in,
	sdram_if.dev bus,
	input wire logic read_latency_setting_in,
	input wire logic [2:0] burst_len_in,
	input wire logic write_burst_mode_bit_in,
	output logic precharge_start_out,
	output logic [1:0] precharge_bank_out,
	output logic write_invalid_out
);
	// ================================================================
	// Storage and command decode
	logic [sdram_pkg::DATA_W-1:0] mem [0:1023];
	logic is_read;
	logic is_write;
	logic is_term;
	logic is_pre;
	logic page_mode;
	logic [2:0] wr_code;
	logic [8:0] wr_len;

	assign is_read = (bus.cmd == sdram_pkg::CMD_READ);
	assign is_write = (bus.cmd == sdram_pkg::CMD_WRITE);
	assign is_term = (bus.cmd == sdram_pkg::CMD_TERM);
	assign is_pre = (bus.cmd == sdram_pkg::CMD_PRE);
	assign page_mode = (burst_len_in == sdram_pkg::BL_PAGE);
	assign wr_code = write_burst_mode_bit_in ? sdram_pkg::BL_1 :
		burst_len_in; // R22
	assign wr_len = sdram_pkg::burst_len(wr_code);

	// ================================================================
	// Output mask delay
	logic dqm_d1;

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			dqm_d1 <= 1'b0;
		end else if (ce_in) begin
			dqm_d1 <= bus.dqm;
		end
	end

	// ================================================================
	// Read burst
	logic rd_act;
	logic rd_page;
	logic rd_ap;
	logic [1:0] rd_bank;
	logic [7:0] rd_col;
	logic [8:0] rd_left;
	logic rd_ap_done;
	logic elem_v;
	logic [sdram_pkg::DATA_W-1:0] elem_d;

	assign elem_v = rd_act;
	assign elem_d = mem[{rd_bank, rd_col}]; // R02
	// A finished auto precharge read, or one cut by a READ or WRITE, closes its row now.
	assign rd_ap_done = rd_act && rd_ap &&
		(rd_left == 9'h000 || is_read || is_write); // R01

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rd_act <= 1'b0;
			rd_page <= 1'b0;
			rd_ap <= 1'b0;
			rd_bank <= 2'h0;
			rd_col <= 8'h00;
			rd_left <= 9'h000;
		end else if (ce_in) begin
			if (is_read) begin // R05 R06
				rd_act <= 1'b1;
				rd_bank <= bus.bank;
				rd_col <= bus.addr;
				rd_page <= page_mode;
				rd_ap <= bus.ap && !page_mode; // R01
				rd_left <= sdram_pkg::burst_len(burst_len_in) - 9'h001;
			end else if (is_write || is_term || is_pre) begin // R12 R11
				rd_act <= 1'b0;
			end else if (rd_act) begin
				rd_col <= sdram_pkg::next_col(rd_col, burst_len_in); // R04
				if (!rd_page) begin
					if (rd_left == 9'h000) begin
						rd_act <= 1'b0; // R03
					end else begin
						rd_left <= rd_left - 9'h001;
					end
				end
			end
		end
	end

	// ================================================================
	// Read pipeline and output drivers
	logic p1_v;
	logic [sdram_pkg::DATA_W-1:0] p1_d;
	logic src_v;
	logic [sdram_pkg::DATA_W-1:0] src_d;
	logic rd_pending;

	assign src_v = read_latency_setting_in ? p1_v : elem_v; // R21
	assign src_d = read_latency_setting_in ? p1_d : elem_d;
	assign rd_pending = rd_act || p1_v || !bus.dev_dq_oe_n;

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			p1_v <= 1'b0;
			p1_d <= '0;
			bus.dev_dq <= '0;
			bus.dev_dq_oe_n <= 1'b1;
		end else if (ce_in) begin
			p1_v <= elem_v && !is_write;
			p1_d <= elem_d;
			bus.dev_dq <= src_d;
			// The mask seen one edge ago gags data two edges on.
			if (is_write) begin
				bus.dev_dq_oe_n <= 1'b1; // R09
			end else begin
				bus.dev_dq_oe_n <= !(src_v && !dqm_d1); // R08 R03
			end
		end
	end

	// ================================================================
	// Write burst
	logic wr_ok;
	logic wr_act;
	logic wr_page;
	logic wr_ap;
	logic [1:0] wr_bank;
	logic [7:0] wr_col;
	logic [8:0] wr_left;
	logic wr_last;
	logic wr_stop;

	// A write that cuts live read data is valid only if masked before.
	assign wr_ok = !(rd_pending && !dqm_d1); // R09
	assign wr_stop = is_read || is_term || is_pre || is_write; // R16 R20
	assign wr_last = wr_act && !wr_page && (wr_left == 9'h000);

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			wr_act <= 1'b0;
			wr_page <= 1'b0;
			wr_ap <= 1'b0;
			wr_bank <= 2'h0;
			wr_col <= 8'h00;
			wr_left <= 9'h000;
		end else if (ce_in) begin
			if (is_write && wr_ok) begin // R15
				wr_act <= (wr_code == sdram_pkg::BL_PAGE) || (wr_len > 9'h001);
				wr_page <= (wr_code == sdram_pkg::BL_PAGE);
				wr_ap <= bus.ap && (wr_code != sdram_pkg::BL_PAGE);
				wr_bank <= bus.bank;
				wr_col <= sdram_pkg::next_col(bus.addr, wr_code);
				wr_left <= wr_len - 9'h002;
			end else if (wr_stop) begin
				wr_act <= 1'b0;
			end else if (wr_act) begin
				wr_col <= sdram_pkg::next_col(wr_col, wr_code); // R04 R23
				if (wr_last) begin
					wr_act <= 1'b0; // R14
				end else if (!wr_page) begin
					wr_left <= wr_left - 9'h001;
				end
			end
		end
	end

	// ================================================================
	// Array write port; mask acts on the same edge as the data.
	always_ff @(posedge sys_clk_in) begin
		if (ce_in && !bus.dqm) begin // R10 R23
			if (is_write && wr_ok) begin
				mem[{bus.bank, bus.addr}] <= bus.dq_level; // R13
			end else if (wr_act && !wr_stop) begin
				mem[{wr_bank, wr_col}] <= bus.dq_level; // R13
			end
		end
	end

	// ================================================================
	// Auto precharge after write recovery
	logic [7:0] rec_cnt;
	logic [1:0] rec_bank;
	logic wr_ap_end;
	logic [1:0] wr_ap_bank;

	// The recovery count starts at the last data edge or at the cutting
	// command, so the precharge never lands on fresh write data.
	assign wr_ap_end = (wr_ap && (wr_last || (wr_act && wr_stop))) ||
		(is_write && wr_ok && bus.ap && wr_len == 9'h001 &&
		!(wr_ap && wr_act));
	assign wr_ap_bank = (wr_ap && wr_act) ? wr_bank : bus.bank;

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rec_cnt <= 8'h00;
			rec_bank <= 2'h0;
		end else if (ce_in) begin
			if (wr_ap_end) begin
				rec_cnt <= 8'(sdram_pkg::WR_CYC); // R18
				rec_bank <= wr_ap_bank;
			end else if (rec_cnt != 8'h00) begin
				rec_cnt <= rec_cnt - 8'h01;
			end
		end
	end

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			precharge_start_out <= 1'b0;
			precharge_bank_out <= 2'h0;
		end else if (ce_in) begin
			if (rec_cnt == 8'h01) begin
				precharge_start_out <= 1'b1; // R18
				precharge_bank_out <= rec_bank;
			end else begin
				precharge_start_out <= rd_ap_done; // R01
				precharge_bank_out <= rd_bank;
			end
		end
	end

	// ================================================================
	// Invalid write flag
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			write_invalid_out <= 1'b0;
		end else if (ce_in) begin
			write_invalid_out <= is_write && !wr_ok; // R09
		end
	end
endmodule : sdram_device

// ===== sdram_pkg.sv
// Shared constants, command codes and burst helpers for both link ends.
// Assumes one 100 MHz clock shared by the controller and the memory end.
// ====================================================================
// How it works
// R01: READ carries bank, column, auto precharge choice.
// R02: First read data one latency later, then each edge.
// R03: Finished read burst releases the data lines.
// R04: Full-page bursts run on, wrapping to column 0.
// R05: New READ may cut or chain read bursts.
// R06: READ accepted every cycle, any bank.
// R07: Controller leaves an idle cycle before WRITE.
// R08: Mask raised early silences read output two clocks later.
// R09: Truncating WRITE forces data lines off if masked before.
// R10: Mask must drop before WRITE; input mask immediate.
// R11: PRECHARGE may end a read, latency-minus-one early.
// R12: BURST TERMINATE ends reads, latency-minus-one early.
// R13: Write data captured from the WRITE edge onward.
// R14: Finished fixed write burst ignores further input data.
// R15: New WRITE any cycle; its data starts the new burst.
// R16: READ stops a write burst at its own edge.
// R17: PRECHARGE after write waits recovery then precharge time.
// R18: Auto precharge after write waits at least one clock.
// R19: Fast clock: mask data around a write-ending PRECHARGE.
// R20: BURST TERMINATE write data is dropped.
// R21: Read latency is two or three clocks.
// R22: Write burst mode bit makes writes single column.
// R23: Masked write edge keeps column, burst still advances.
package sdram_pkg;

	// ================================================================
	// Widths
	localparam int DATA_W = 16;
	localparam int COL_W = 8;
	localparam int BANK_W = 2;
	localparam int FIFO_DEPTH = 4;

	// ================================================================
	// Command codes as {row strobe, column strobe, write strobe}, low active
	localparam logic [2:0] CMD_NOP = 3'h7;
	localparam logic [2:0] CMD_READ = 3'h5;
	localparam logic [2:0] CMD_WRITE = 3'h4;
	localparam logic [2:0] CMD_TERM = 3'h6;
	localparam logic [2:0] CMD_PRE = 3'h2;

	// ================================================================
	// Burst length codes
	localparam logic [2:0] BL_1 = 3'h0;
	localparam logic [2:0] BL_2 = 3'h1;
	localparam logic [2:0] BL_4 = 3'h2;
	localparam logic [2:0] BL_8 = 3'h3;
	localparam logic [2:0] BL_PAGE = 3'h7;

	// ================================================================
	// Timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int WRITE_RECOVERY_TIME_NS = 15;
	localparam int PRECHARGE_WAIT_TIME_NS = 20;
	localparam int WR_RAW = (WRITE_RECOVERY_TIME_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int WR_CYC = (WR_RAW < 1) ? 1 : WR_RAW;
	localparam int RP_RAW = (PRECHARGE_WAIT_TIME_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int RP_CYC = (RP_RAW < 1) ? 1 : RP_RAW;

	// ================================================================
	// Helpers
	function automatic logic [8:0] burst_len(input logic [2:0] code);
		unique case (code)
			BL_2: burst_len = 9'h002;
			BL_4: burst_len = 9'h004;
			BL_8: burst_len = 9'h008;
			BL_PAGE: burst_len = 9'h100;
			default: burst_len = 9'h001;
		endcase
	endfunction : burst_len

	function automatic logic [COL_W-1:0] next_col(
		input logic [COL_W-1:0] col, input logic [2:0] code);
		unique case (code)
			BL_2: next_col = {col[7:1], ~col[0]};
			BL_4: next_col = {col[7:2], col[1:0] + 2'h1};
			BL_8: next_col = {col[7:3], col[2:0] + 3'h1};
			default: next_col = col + 8'h01;
		endcase
	endfunction : next_col

	function automatic logic [1:0] read_latency(input logic setting);
		read_latency = setting ? 2'h3 : 2'h2;
	endfunction : read_latency

endpackage : sdram_pkg

// ===== sdram_if.sv
// Command, mask and shared data lines between controller and memory.
// Assumes each end drives its data only while its enable (low) is active.
interface sdram_if;
	logic [2:0] cmd;
	logic [sdram_pkg::BANK_W-1:0] bank;
	logic [sdram_pkg::COL_W-1:0] addr;
	logic ap;
	logic dqm;
	logic [sdram_pkg::DATA_W-1:0] ctl_dq;
	logic ctl_dq_oe_n;
	logic [sdram_pkg::DATA_W-1:0] dev_dq;
	logic dev_dq_oe_n;
	logic [sdram_pkg::DATA_W-1:0] dq_level;

	// ================================================================
	// Bus level; an undriven bus reads as zero.
	assign dq_level = !ctl_dq_oe_n ? ctl_dq :
		(!dev_dq_oe_n ? dev_dq : '0);

	modport ctrl (output cmd, bank, addr, ap, dqm, ctl_dq, ctl_dq_oe_n,
		input dq_level);
	modport dev (input cmd, bank, addr, ap, dqm, dq_level,
		output dev_dq, dev_dq_oe_n);
endinterface : sdram_if

// ===== sdram_fifo.sv
// Small request FIFO with valid and ready on both sides.
// Assumes one clock; flags come from flip-flops.
module sdram_fifo #(
	parameter int WIDTH = 28,
	parameter int DEPTH = 4
) (
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	input wire logic ce_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [WIDTH-1:0] in_data_in,
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [WIDTH-1:0] out_data_out
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] store [0:DEPTH-1];
	logic [AW-1:0] wp;
	logic [AW-1:0] rp;
	logic [AW:0] cnt;
	logic [AW:0] next_cnt;
	logic push;
	logic pop;

	assign push = in_valid_in && in_ready_out;
	assign pop = out_valid_out && out_ready_in;
	assign out_data_out = store[rp];
	assign next_cnt = cnt + (AW+1)'(push) - (AW+1)'(pop);

	always_ff @(posedge sys_clk_in) begin
		if (ce_in && push) begin
			store[wp] <= in_data_in;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			wp <= '0;
			rp <= '0;
			cnt <= '0;
			in_ready_out <= 1'b1;
			out_valid_out <= 1'b0;
		end else if (ce_in) begin
			if (push) begin
				wp <= (wp == AW'(DEPTH - 1)) ? '0 : wp + AW'(1);
			end
			if (pop) begin
				rp <= (rp == AW'(DEPTH - 1)) ? '0 : rp + AW'(1);
			end
			cnt <= next_cnt;
			in_ready_out <= (next_cnt != (AW+1)'(DEPTH));
			out_valid_out <= (next_cnt != '0);
		end
	end
endmodule : sdram_fifo

// ===== sdram_ctrl.sv
// Controller end: queues single-word requests and sequences commands.
// Assumes the memory end uses the same latency and burst settings.
module sdram_ctrl (
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	input wire logic ce_in,
	sdram_if.ctrl bus,
	input wire logic read_latency_setting_in,
	input wire logic [2:0] burst_len_in,
	input wire logic req_valid_in,
	output logic req_ready_out,
	input wire logic req_write_in,
	input wire logic [1:0] req_bank_in,
	input wire logic [7:0] req_col_in,
	input wire logic req_close_in,
	input wire logic [15:0] req_data_in,
	output logic rsp_valid_out,
	output logic [15:0] rsp_data_out
);
	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_STOP = 3'h2,
		ST_WAIT = 3'h4
	} state_t;

	state_t state;
	logic q_valid;
	logic [27:0] q_data;
	logic op_wr;
	logic op_close;
	logic [9:0] ctr;
	logic [9:0] wait_len;
	logic [8:0] len;
	logic [1:0] lat;

	assign lat = sdram_pkg::read_latency(read_latency_setting_in);
	assign len = sdram_pkg::burst_len(burst_len_in);

	sdram_fifo #(.WIDTH(28), .DEPTH(sdram_pkg::FIFO_DEPTH)) u_fifo (
		.sys_clk_in(sys_clk_in),
		.rstn_in(rstn_in),
		.ce_in(ce_in),
		.in_valid_in(req_valid_in),
		.in_ready_out(req_ready_out),
		.in_data_in({req_write_in, req_close_in, req_bank_in, req_col_in,
			req_data_in}),
		.out_valid_out(q_valid),
		.out_ready_in(state == ST_IDLE),
		.out_data_out(q_data)
	);

	// ================================================================
	// Sequencer
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state <= ST_IDLE;
			op_wr <= 1'b0;
			op_close <= 1'b0;
			ctr <= 10'h000;
			wait_len <= 10'h000;
			bus.cmd <= sdram_pkg::CMD_NOP;
			bus.bank <= 2'h0;
			bus.addr <= 8'h00;
			bus.ap <= 1'b0;
			bus.dqm <= 1'b0;
			bus.ctl_dq <= '0;
			bus.ctl_dq_oe_n <= 1'b1;
			rsp_valid_out <= 1'b0;
			rsp_data_out <= '0;
		end else if (ce_in) begin
			rsp_valid_out <= 1'b0;
			unique case (state)
				ST_IDLE: begin
					bus.cmd <= sdram_pkg::CMD_NOP;
					bus.ctl_dq_oe_n <= 1'b1;
					if (q_valid) begin
						op_wr <= q_data[27];
						op_close <= q_data[26];
						bus.cmd <= q_data[27] ? sdram_pkg::CMD_WRITE :
							sdram_pkg::CMD_READ;
						bus.bank <= q_data[25:24]; // R01
						bus.addr <= q_data[23:16];
						bus.ap <= q_data[27] && q_data[26];
						bus.dqm <= 1'b0; // R10
						bus.ctl_dq <= q_data[15:0]; // R13
						bus.ctl_dq_oe_n <= !q_data[27];
						state <= ST_STOP;
					end
				end
				ST_STOP: begin
					bus.ap <= 1'b0;
					bus.ctl_dq_oe_n <= 1'b1;
					ctr <= 10'h001;
					if (!op_wr) begin
						// Issued latency-minus-one before the wanted word.
						bus.cmd <= op_close ? sdram_pkg::CMD_PRE : // R11
							(len == 9'h001 ? sdram_pkg::CMD_NOP :
							sdram_pkg::CMD_TERM); // R12 R05
						wait_len <= 10'(lat) + (op_close ?
							10'(sdram_pkg::RP_CYC) : 10'h000) + 10'h001; // R07
					end else if (op_close) begin
						// Auto precharge write: the tail is masked off.
						bus.cmd <= sdram_pkg::CMD_NOP;
						bus.dqm <= 1'b1; // R19 R23
						wait_len <= 10'(len) + 10'(sdram_pkg::WR_CYC) +
							10'(sdram_pkg::RP_CYC); // R17
					end else begin
						bus.cmd <= (len == 9'h001) ? sdram_pkg::CMD_NOP :
							sdram_pkg::CMD_TERM; // R20
						wait_len <= 10'h001;
					end
					state <= ST_WAIT;
				end
				ST_WAIT: begin
					bus.cmd <= sdram_pkg::CMD_NOP;
					ctr <= ctr + 10'h001;
					if (!op_wr && ctr == 10'(lat)) begin
						rsp_valid_out <= 1'b1; // R02
						rsp_data_out <= bus.dq_level;
					end
					if (!op_wr && ctr > 10'(lat)) begin
						bus.dqm <= 1'b1; // R08
					end
					if (ctr >= wait_len) begin
						state <= ST_IDLE;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end
endmodule : sdram_ctrl

// ===== sdram_link_properties.sv
// Checker for the link between the controller end and the memory end.
// Assumes one clock and the link signals handed in by name.
module sdram_link_properties (
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	input wire logic read_latency_setting_in,
	input wire logic [2:0] cmd_in,
	input wire logic dqm_in,
	input wire logic ctl_dq_oe_n_in,
	input wire logic dev_dq_oe_n_in
);
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (!rstn_in);

	// ================================================================
	// Link properties
	a_no_bus_fight: assert property (
		ctl_dq_oe_n_in || dev_dq_oe_n_in)
		else $error("both ends drive the data bus");
	a_write_drives_data: assert property (
		cmd_in == sdram_pkg::CMD_WRITE |-> !ctl_dq_oe_n_in)
		else $error("write issued without its first data");
	a_drive_only_write: assert property (
		$fell(ctl_dq_oe_n_in) |-> cmd_in == sdram_pkg::CMD_WRITE)
		else $error("controller drives data outside a write");
	a_read_data_latency: assert property (
		$fell(dev_dq_oe_n_in) |-> (read_latency_setting_in ?
		$past(cmd_in, 3) : $past(cmd_in, 2)) == sdram_pkg::CMD_READ)
		else $error("read data does not follow the read latency");
	a_write_silences_dev: assert property (
		cmd_in == sdram_pkg::CMD_WRITE |-> dev_dq_oe_n_in ##1
		dev_dq_oe_n_in)
		else $error("memory drives data after a write");
	a_term_ends_read: assert property (
		cmd_in == sdram_pkg::CMD_TERM ##1 cmd_in == sdram_pkg::CMD_NOP [*2]
		|=> dev_dq_oe_n_in)
		else $error("read burst runs past its terminate");
	a_mask_stops_output: assert property (
		dqm_in |-> ##2 dev_dq_oe_n_in)
		else $error("mask did not silence the output");
	a_write_mask_low: assert property (
		cmd_in == sdram_pkg::CMD_WRITE |-> !dqm_in)
		else $error("write data masked at the write edge");
	a_idle_before_write: assert property (
		cmd_in == sdram_pkg::CMD_WRITE |-> $past(dev_dq_oe_n_in))
		else $error("no idle cycle between read data and write");
endmodule : sdram_link_properties

// ===== sdram_burst_read_write_bench.sv
// Bench: controller and memory joined by one link, plus a second memory
// end driven directly by the bench. Assumes the design files come first.
module sdram_burst_read_write_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk_in = 1'b0;
	logic rstn_in = 1'b0;
	logic lat_sel = 1'b0;
	logic ce = 1'b1;
	logic [2:0] bl = sdram_pkg::BL_4;
	logic req_valid = 1'b0;
	logic req_write = 1'b0;
	logic [7:0] req_col = 8'h00;
	logic req_close = 1'b0;
	logic [15:0] req_data = 16'h0000;
	logic req_ready, rsp_valid, pre_start, inv2;
	logic [1:0] pre_bank;
	logic [1:0] last_pre_bank = 2'h0;
	logic [15:0] rsp_data;
	logic [15:0] rq[$];
	logic [2:0] codes[5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
	int err_count = 0;
	int n_compared = 0;
	int cycles = 0;
	int pre_cnt = 0;
	int inv_cnt = 0;
	logic full_seen = 1'b0;
	sdram_if link();
	sdram_if probe();
	always #5 sys_clk_in = ~sys_clk_in;

	// ================================================================
	// Design ends and checker
	sdram_ctrl sdram_ctrl_inst (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
		.ce_in(ce), .bus(link.ctrl), .read_latency_setting_in(lat_sel),
		.burst_len_in(bl), .req_valid_in(req_valid),
		.req_ready_out(req_ready), .req_write_in(req_write),
		.req_bank_in(req_col[1:0]), .req_col_in(req_col),
		.req_close_in(req_close), .req_data_in(req_data),
		.rsp_valid_out(rsp_valid), .rsp_data_out(rsp_data));
	sdram_device sdram_device_inst (.sys_clk_in(sys_clk_in),
		.rstn_in(rstn_in), .ce_in(ce), .bus(link.dev),
		.read_latency_setting_in(lat_sel), .burst_len_in(bl),
		.write_burst_mode_bit_in(lat_sel), .precharge_start_out(pre_start),
		.precharge_bank_out(pre_bank), .write_invalid_out());
	sdram_device sdram_device_b_inst (.sys_clk_in(sys_clk_in),
		.rstn_in(rstn_in), .ce_in(ce), .bus(probe.dev),
		.read_latency_setting_in(1'b0), .burst_len_in(3'h2),
		.write_burst_mode_bit_in(1'b0), .precharge_start_out(),
		.precharge_bank_out(), .write_invalid_out(inv2));
	sdram_link_properties sdram_link_properties_inst (
		.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
		.read_latency_setting_in(lat_sel), .cmd_in(link.cmd),
		.dqm_in(link.dqm), .ctl_dq_oe_n_in(link.ctl_dq_oe_n),
		.dev_dq_oe_n_in(link.dev_dq_oe_n));

	// ================================================================
	// Monitors and shared tasks
	always @(posedge sys_clk_in) begin
		cycles++;
		if (rsp_valid === 1'b1)
			rq.push_back(rsp_data);
		if (pre_start === 1'b1) begin
			pre_cnt++;
			last_pre_bank = pre_bank;
		end
		if (inv2 === 1'b1)
			inv_cnt++;
		if (cycles == 20000) begin
			err_count++;
			complete_run();
		end
	end

	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// A zero data word means the bench leaves the data lines released.
	task automatic drv(input logic [2:0] c, input logic [7:0] a,
		input logic m, input logic [15:0] d);
		@(negedge sys_clk_in);
		probe.cmd = c;
		probe.addr = a;
		probe.dqm = m;
		probe.ctl_dq = d;
		probe.ctl_dq_oe_n = (d == 16'h0000);
	endtask : drv

	task automatic push(input logic w, input logic [7:0] col,
		input logic cls);
		int n;
		logic got;
		n = 0;
		got = 1'b0;
		@(negedge sys_clk_in);
		req_valid = 1'b1;
		req_write = w;
		req_col = col;
		req_close = cls;
		req_data = {col, ~col};
		do begin
			@(posedge sys_clk_in);
			n++;
			got = (req_ready === 1'b1);
			if (!got)
				full_seen = 1'b1;
		end while (!got && n < 100);
		// A request never taken counts against the run.
		if (!got)
			err_count++;
	endtask : push

	// ================================================================
	// Scenarios
	task automatic t_dev();
		for (int i = 0; i < 5; i++)
			drv(i ? 3'h7 : 3'h4, 8'h08, 1'b0,
				i < 4 ? 16'h5500 + 16'(i) : 16'h0000);
		drv(3'h4, 8'h08, 1'b0, 16'h66a0);
		drv(3'h7, 8'h08, 1'b1, 16'h66a1);
		drv(3'h7, 8'h08, 1'b0, 16'h66a2);
		drv(3'h6, 8'h08, 1'b0, 16'h66a3);
		drv(3'h5, 8'h08, 1'b0, 16'h0000);
		for (int i = 0; i < 6; i++) begin
			drv(3'h7, 8'h08, 1'b0, 16'h0000);
			if (i >= 1 && i <= 4)
				check("read word", probe.dq_level,
					i[0] ? 16'h669f + 16'(i) : 16'h54ff + 16'(i));
		end
		check("released", 16'(probe.dev_dq_oe_n), 16'h0001);
		// A read offered while the enable is low must not be taken.
		ce = 1'b0;
		drv(3'h5, 8'h08, 1'b0, 16'h0000);
		drv(3'h7, 8'h08, 1'b0, 16'h0000);
		drv(3'h7, 8'h08, 1'b0, 16'h0000);
		drv(3'h7, 8'h08, 1'b0, 16'h0000);
		check("frozen read", 16'(probe.dev_dq_oe_n), 16'h0001);
		ce = 1'b1;
		drv(3'h5, 8'h08, 1'b0, 16'h0000);
		drv(3'h4, 8'h0c, 1'b0, 16'h0077);
		drv(3'h7, 8'h08, 1'b0, 16'h0000);
		drv(3'h7, 8'h08, 1'b0, 16'h0000);
		check("refused writes", 16'(inv_cnt), 16'h0001);
		drv(3'h5, 8'h08, 1'b0, 16'h0000);
		drv(3'h7, 8'h08, 1'b1, 16'h0000);
		drv(3'h7, 8'h08, 1'b1, 16'h0000);
		drv(3'h4, 8'h0c, 1'b0, 16'h0078);
		drv(3'h7, 8'h08, 1'b0, 16'h0000);
		drv(3'h7, 8'h08, 1'b0, 16'h0000);
		check("refused writes", 16'(inv_cnt), 16'h0001);
		$display("test t_dev done");
	endtask : t_dev

	// Three writes, three reads and one rewrite, queued back to back so
	// that the last request meets a full FIFO.
	task automatic t_rw(input logic c, input logic [2:0] b);
		int n;
		int base;
		n = 0;
		@(negedge sys_clk_in);
		lat_sel = c;
		bl = b;
		rq.delete();
		base = pre_cnt;
		for (int i = 0; i < 7; i++)
			push(i < 3 || i == 6, {c, b, 4'(i % 3)},
				i % 3 == 1 && b != 3'h7);
		@(negedge sys_clk_in);
		req_valid = 1'b0;
		while (rq.size() < 3 && n < 300) begin
			@(posedge sys_clk_in);
			n++;
		end
		repeat (10) @(posedge sys_clk_in);
		check("reads answered", 16'(rq.size()), 16'h0003);
		for (int k = 0; k < 3; k++)
			check("read back", rq[k], {c, b, 4'(k), ~{c, b, 4'(k)}});
		check("auto precharge", 16'(pre_cnt - base),
			16'(b != 3'h7));
		if (b != 3'h7)
			check("precharge bank", 16'(last_pre_bank), 16'h0001);
		$display("test t_rw lat=%0d bl=%0d done", c, b);
	endtask : t_rw

	task automatic complete_run();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : complete_run

	initial begin
		probe.cmd = sdram_pkg::CMD_NOP;
		probe.bank = 2'h0;
		probe.addr = 8'h00;
		probe.ap = 1'b0;
		probe.dqm = 1'b0;
		probe.ctl_dq = 16'h0000;
		probe.ctl_dq_oe_n = 1'b1;
		repeat (6) @(posedge sys_clk_in);
		@(negedge sys_clk_in);
		rstn_in = 1'b1;
		t_dev();
		for (int c = 0; c < 2; c++)
			foreach (codes[k])
				t_rw(1'(c), codes[k]);
		check("fifo full seen", 16'(full_seen), 16'h0001);
		complete_run();
	end
endmodule : sdram_burst_read_write_bench
